/* File: design/stib_pkg.sv */
/*
 * Constants for the sampling-instant trim bank: register offsets,
 * register indices, widths and the value applied to an idle core.
 * Assumes a single 40 MHz register clock shared with the calibration logic.
 */
package stib_pkg;

    // ==========================================================
    // Widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int NUM_TRIM = 7;
    localparam int IDX_W = 3;

    // ==========================================================
    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_CORE_A_SINGLE_FG_PHASE90 = 12'h080;
    localparam logic [ADDR_W-1:0] OFS_CORE_B_SINGLE_FG_PHASE0 = 12'h081;
    localparam logic [ADDR_W-1:0] OFS_CORE_A_SINGLE_BG_PHASE90 = 12'h082;
    localparam logic [ADDR_W-1:0] OFS_CORE_C_SINGLE_BG_PHASE0 = 12'h083;
    localparam logic [ADDR_W-1:0] OFS_CORE_C_SINGLE_BG_PHASE90 = 12'h084;
    localparam logic [ADDR_W-1:0] OFS_CORE_B_SINGLE_BG_PHASE0 = 12'h085;
    localparam logic [ADDR_W-1:0] OFS_CORE_A_DUAL_MODE = 12'h086;

    // ==========================================================
    // Register indices inside the bank
    localparam logic [IDX_W-1:0] IDX_CORE_A_SINGLE_FG_PHASE90 = 3'h0;
    localparam logic [IDX_W-1:0] IDX_CORE_B_SINGLE_FG_PHASE0 = 3'h1;
    localparam logic [IDX_W-1:0] IDX_CORE_A_SINGLE_BG_PHASE90 = 3'h2;
    localparam logic [IDX_W-1:0] IDX_CORE_C_SINGLE_BG_PHASE0 = 3'h3;
    localparam logic [IDX_W-1:0] IDX_CORE_C_SINGLE_BG_PHASE90 = 3'h4;
    localparam logic [IDX_W-1:0] IDX_CORE_B_SINGLE_BG_PHASE0 = 3'h5;
    localparam logic [IDX_W-1:0] IDX_CORE_A_DUAL_MODE = 3'h6;

    // ==========================================================
    // Values
    localparam logic [DATA_W-1:0] TRIM_IDLE = 8'h00;
    localparam logic [DATA_W-1:0] RDATA_NONE = 8'h00;

    typedef enum logic [1:0] {
        MODE_SINGLE_FG,
        MODE_SINGLE_BG,
        MODE_DUAL
    } stib_mode_e;

endpackage

/* File: design/stib_top.sv */
/*
 * Sampling-instant trim bank: seven 8-bit trim registers behind a plain
 * register port, and the selection of the trim applied to each core.
 * Assumes mode, calibration and phase inputs and the factory trim values
 * come from logic on CLK_I; the factory values are stable during reset.
 */
// Strobed register access was left to the implementer.
// Summary of operation
// - Each trim register value shifts its core's sampling instant via the core outputs.
// - Mode and background phase pick which register drives each core.
// - Reset loads factory trims; software reads and overwrites them, then they apply.
// - Single mode, foreground calibration: core B uses register 0x081.
// - Single mode, background calibration: core A uses register 0x082.
// - Single background calibration: core C uses 0x083 at phase zero, 0x084 at ninety.
// - Single mode, background calibration: core B uses register 0x085.
// - Dual-channel mode: core A uses register 0x086.
// - Single mode, foreground calibration: core A uses register 0x080.
`timescale 1ns/1ps

module stib_top
    import stib_pkg::*;
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // Register port
    input wire logic [stib_pkg::ADDR_W-1:0] ADDR_I,
    input wire logic [stib_pkg::DATA_W-1:0] WDATA_I,
    input wire logic WR_STB_I,
    input wire logic RD_STB_I,
    output logic [stib_pkg::DATA_W-1:0] RDATA_O,
    // Operating mode
    input wire logic DUAL_MODE_I,
    input wire logic BG_CAL_I,
    input wire logic BG_PHASE90_I,
    // Factory trim values
    input wire logic [stib_pkg::DATA_W-1:0] FACTORY_CORE_A_SINGLE_FG_PHASE90_DELAY_I,
    input wire logic [stib_pkg::DATA_W-1:0] FACTORY_CORE_B_SINGLE_FG_PHASE0_DELAY_I,
    input wire logic [stib_pkg::DATA_W-1:0] FACTORY_CORE_A_SINGLE_BG_PHASE90_DELAY_I,
    input wire logic [stib_pkg::DATA_W-1:0] FACTORY_CORE_C_SINGLE_BG_PHASE0_DELAY_I,
    input wire logic [stib_pkg::DATA_W-1:0] FACTORY_CORE_C_SINGLE_BG_PHASE90_DELAY_I,
    input wire logic [stib_pkg::DATA_W-1:0] FACTORY_CORE_B_SINGLE_BG_PHASE0_DELAY_I,
    input wire logic [stib_pkg::DATA_W-1:0] FACTORY_CORE_A_DUAL_MODE_DELAY_I,
    // Applied trims
    output logic [stib_pkg::DATA_W-1:0] CORE_A_DELAY_O,
    output logic [stib_pkg::DATA_W-1:0] CORE_B_DELAY_O,
    output logic [stib_pkg::DATA_W-1:0] CORE_C_DELAY_O
);
    import stib_pkg::*;

    // ==========================================================
    // Address decode
    // Returns {hit, index}; index is meaningless on a miss
    function automatic logic [IDX_W:0] decode_addr(input logic [ADDR_W-1:0] addr);
        logic [IDX_W:0] res;
        res = {1'b0, IDX_CORE_A_SINGLE_FG_PHASE90};
        case (addr)
            OFS_CORE_A_SINGLE_FG_PHASE90: res = {1'b1, IDX_CORE_A_SINGLE_FG_PHASE90};
            OFS_CORE_B_SINGLE_FG_PHASE0: res = {1'b1, IDX_CORE_B_SINGLE_FG_PHASE0};
            OFS_CORE_A_SINGLE_BG_PHASE90: res = {1'b1, IDX_CORE_A_SINGLE_BG_PHASE90};
            OFS_CORE_C_SINGLE_BG_PHASE0: res = {1'b1, IDX_CORE_C_SINGLE_BG_PHASE0};
            OFS_CORE_C_SINGLE_BG_PHASE90: res = {1'b1, IDX_CORE_C_SINGLE_BG_PHASE90};
            OFS_CORE_B_SINGLE_BG_PHASE0: res = {1'b1, IDX_CORE_B_SINGLE_BG_PHASE0};
            OFS_CORE_A_DUAL_MODE: res = {1'b1, IDX_CORE_A_DUAL_MODE};
            default: res = {1'b0, IDX_CORE_A_SINGLE_FG_PHASE90};
        endcase
        return res;
    endfunction

    // ==========================================================
    // Trim registers
    logic [DATA_W-1:0] factory_w [NUM_TRIM];
    logic [DATA_W-1:0] trim_r [NUM_TRIM];
    logic [DATA_W-1:0] trim_nxt [NUM_TRIM];
    logic [IDX_W:0] wr_dec;
    logic [IDX_W:0] rd_dec;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;

    assign factory_w[IDX_CORE_A_SINGLE_FG_PHASE90] = FACTORY_CORE_A_SINGLE_FG_PHASE90_DELAY_I;
    assign factory_w[IDX_CORE_B_SINGLE_FG_PHASE0] = FACTORY_CORE_B_SINGLE_FG_PHASE0_DELAY_I;
    assign factory_w[IDX_CORE_A_SINGLE_BG_PHASE90] = FACTORY_CORE_A_SINGLE_BG_PHASE90_DELAY_I;
    assign factory_w[IDX_CORE_C_SINGLE_BG_PHASE0] = FACTORY_CORE_C_SINGLE_BG_PHASE0_DELAY_I;
    assign factory_w[IDX_CORE_C_SINGLE_BG_PHASE90] = FACTORY_CORE_C_SINGLE_BG_PHASE90_DELAY_I;
    assign factory_w[IDX_CORE_B_SINGLE_BG_PHASE0] = FACTORY_CORE_B_SINGLE_BG_PHASE0_DELAY_I;
    assign factory_w[IDX_CORE_A_DUAL_MODE] = FACTORY_CORE_A_DUAL_MODE_DELAY_I;

    assign wr_dec = decode_addr(ADDR_I);
    assign rd_dec = decode_addr(ADDR_I);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_TRIM; gi++) begin : g_trim
            always_comb begin
                trim_nxt[gi] = trim_r[gi];
                // Sync reset reloads the fuse value, so no value is undefined after the first reset edge
                if (RST_I) begin
                    trim_nxt[gi] = factory_w[gi];
                end else if (WR_STB_I && wr_dec[IDX_W] && wr_dec[IDX_W-1:0] == gi) begin
                    trim_nxt[gi] = WDATA_I;
                end
            end

            always_ff @(posedge CLK_I) begin
                trim_r[gi] <= trim_nxt[gi];
            end
        end
    endgenerate

    // ==========================================================
    // Read path
    // Data stand only in the cycle after the strobe; zero otherwise
    always_comb begin
        rdata_nxt = RDATA_NONE;
        if (!RST_I && RD_STB_I && rd_dec[IDX_W]) begin
            rdata_nxt = trim_r[rd_dec[IDX_W-1:0]];
        end
    end

    always_ff @(posedge CLK_I) begin
        rdata_r <= rdata_nxt;
    end

    assign RDATA_O = rdata_r;

    // ==========================================================
    // Trim selection per core
    stib_mode_e mode_w;
    logic [DATA_W-1:0] core_a_r;
    logic [DATA_W-1:0] core_b_r;
    logic [DATA_W-1:0] core_c_r;
    logic [DATA_W-1:0] core_a_nxt;
    logic [DATA_W-1:0] core_b_nxt;
    logic [DATA_W-1:0] core_c_nxt;

    always_comb begin
        if (DUAL_MODE_I) begin
            mode_w = MODE_DUAL;
        end else if (BG_CAL_I) begin
            mode_w = MODE_SINGLE_BG;
        end else begin
            mode_w = MODE_SINGLE_FG;
        end
    end

    // Cores without a register for the current mode get zero shift
    always_comb begin
        core_a_nxt = TRIM_IDLE;
        core_b_nxt = TRIM_IDLE;
        core_c_nxt = TRIM_IDLE;
        if (!RST_I) begin
            case (mode_w)
                MODE_SINGLE_FG: begin
                    core_a_nxt = trim_r[IDX_CORE_A_SINGLE_FG_PHASE90];
                    core_b_nxt = trim_r[IDX_CORE_B_SINGLE_FG_PHASE0];
                end
                MODE_SINGLE_BG: begin
                    core_a_nxt = trim_r[IDX_CORE_A_SINGLE_BG_PHASE90];
                    core_b_nxt = trim_r[IDX_CORE_B_SINGLE_BG_PHASE0];
                    if (BG_PHASE90_I) begin
                        core_c_nxt = trim_r[IDX_CORE_C_SINGLE_BG_PHASE90];
                    end else begin
                        core_c_nxt = trim_r[IDX_CORE_C_SINGLE_BG_PHASE0];
                    end
                end
                MODE_DUAL: begin
                    core_a_nxt = trim_r[IDX_CORE_A_DUAL_MODE];
                end
                default: begin
                    core_a_nxt = TRIM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        core_a_r <= core_a_nxt;
        core_b_r <= core_b_nxt;
        core_c_r <= core_c_nxt;
    end

    // Registered outputs feed the delay lines directly
    assign CORE_A_DELAY_O = core_a_r;
    assign CORE_B_DELAY_O = core_b_r;
    assign CORE_C_DELAY_O = core_c_r;

endmodule

/* File: tb/stib_chk.sv */
/* Checker for the trim bank: read data against the applied core trims.
   Assumes it is bound to stib_top, on the single register clock. */
`timescale 1ns/1ps
module stib_chk
    import stib_pkg::*;
(
    // Register port
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic RD_STB_I,
    input wire logic [DATA_W-1:0] RDATA_O,
    // Mode and applied trims
    input wire logic DUAL_MODE_I,
    input wire logic BG_CAL_I,
    input wire logic BG_PHASE90_I,
    input wire logic [DATA_W-1:0] CORE_A_DELAY_O,
    input wire logic [DATA_W-1:0] CORE_B_DELAY_O,
    input wire logic [DATA_W-1:0] CORE_C_DELAY_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // Read and selection both see the register before the edge, so writes never skew them
    wire fg = !DUAL_MODE_I && !BG_CAL_I;
    wire bg = !DUAL_MODE_I && BG_CAL_I;
    a_map_a_fg: assert property (RD_STB_I && fg &&
        ADDR_I == OFS_CORE_A_SINGLE_FG_PHASE90 |=> RDATA_O == CORE_A_DELAY_O)
        else $error("core A fg trim differs");
    a_map_b_fg: assert property (RD_STB_I && fg &&
        ADDR_I == OFS_CORE_B_SINGLE_FG_PHASE0 |=> RDATA_O == CORE_B_DELAY_O)
        else $error("core B fg trim differs");
    a_map_a_bg: assert property (RD_STB_I && bg &&
        ADDR_I == OFS_CORE_A_SINGLE_BG_PHASE90 |=> RDATA_O == CORE_A_DELAY_O)
        else $error("core A bg trim differs");
    a_map_c_zero: assert property (RD_STB_I && bg && !BG_PHASE90_I &&
        ADDR_I == OFS_CORE_C_SINGLE_BG_PHASE0 |=> RDATA_O == CORE_C_DELAY_O)
        else $error("core C phase zero trim differs");
    a_map_c_ninety: assert property (RD_STB_I && bg && BG_PHASE90_I &&
        ADDR_I == OFS_CORE_C_SINGLE_BG_PHASE90 |=> RDATA_O == CORE_C_DELAY_O)
        else $error("core C ninety trim differs");
    a_map_b_bg: assert property (RD_STB_I && bg &&
        ADDR_I == OFS_CORE_B_SINGLE_BG_PHASE0 |=> RDATA_O == CORE_B_DELAY_O)
        else $error("core B bg trim differs");
    a_map_a_dual: assert property (RD_STB_I && DUAL_MODE_I &&
        ADDR_I == OFS_CORE_A_DUAL_MODE |=> RDATA_O == CORE_A_DELAY_O)
        else $error("core A dual trim differs");
    a_rd_idle_zero: assert property (!RD_STB_I |=> RDATA_O == RDATA_NONE)
        else $error("read data not idle");
endmodule
bind stib_top stib_chk u_stib_chk (.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
    .RD_STB_I(RD_STB_I), .RDATA_O(RDATA_O), .DUAL_MODE_I(DUAL_MODE_I), .BG_CAL_I(BG_CAL_I),
    .BG_PHASE90_I(BG_PHASE90_I), .CORE_A_DELAY_O(CORE_A_DELAY_O),
    .CORE_B_DELAY_O(CORE_B_DELAY_O), .CORE_C_DELAY_O(CORE_C_DELAY_O));

/* File: tb/tb_stib_top.sv */
/* Bench for the trim bank: factory load, write and readback, core selection.
   Assumes the checker is bound to the design from its own file. */
`timescale 1ns/1ps
module tb_stib_top;
    import stib_pkg::*;
    logic clk = 0, rst = 1, wr = 0, rs = 0, dual = 0, bg = 0, ph = 0;
    logic [ADDR_W-1:0] addr = 12'h000;
    logic [DATA_W-1:0] wd = 8'h00, rdata, ca, cb, cc;
    logic [DATA_W-1:0] fac [NUM_TRIM], cur [NUM_TRIM];
    int errors = 0, tests_run = 0, cyc = 0;
    stib_top u_stib_top (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wd),
        .WR_STB_I(wr), .RD_STB_I(rs), .RDATA_O(rdata), .DUAL_MODE_I(dual),
        .BG_CAL_I(bg), .BG_PHASE90_I(ph),
        .FACTORY_CORE_A_SINGLE_FG_PHASE90_DELAY_I(fac[0]),
        .FACTORY_CORE_B_SINGLE_FG_PHASE0_DELAY_I(fac[1]),
        .FACTORY_CORE_A_SINGLE_BG_PHASE90_DELAY_I(fac[2]),
        .FACTORY_CORE_C_SINGLE_BG_PHASE0_DELAY_I(fac[3]),
        .FACTORY_CORE_C_SINGLE_BG_PHASE90_DELAY_I(fac[4]),
        .FACTORY_CORE_B_SINGLE_BG_PHASE0_DELAY_I(fac[5]),
        .FACTORY_CORE_A_DUAL_MODE_DELAY_I(fac[6]),
        .CORE_A_DELAY_O(ca), .CORE_B_DELAY_O(cb), .CORE_C_DELAY_O(cc));
    // Distinct fuse values, so a swapped register shows up
    initial for (int i = 0; i < NUM_TRIM; i++) fac[i] = 8'h3C + 8'(i * 17);
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            errors++;
            results();
        end
    end
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr_reg(logic [11:0] a, logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stands one cycle only, so it is sampled just after that edge
    task automatic rd_reg(logic [11:0] a, logic [7:0] e);
        @(posedge clk);
        rs <= 1'b1; addr <= a;
        @(posedge clk);
        rs <= 1'b0;
        #1 chk("rdata", e, rdata);
    endtask
    task automatic rd_all();
        for (int i = 0; i < NUM_TRIM; i++)
            rd_reg(OFS_CORE_A_SINGLE_FG_PHASE90 + 12'(i), cur[i]);
    endtask
    task automatic t_reset();
        cur = fac;
        rd_all();
        rd_reg(OFS_CORE_A_DUAL_MODE + 12'h001, RDATA_NONE);
    endtask
    task automatic t_write();
        for (int i = 0; i < NUM_TRIM; i++) begin
            cur[i] = ~fac[i];
            wr_reg(OFS_CORE_A_SINGLE_FG_PHASE90 + 12'(i), cur[i]);
        end
        // Unmapped write must not alias onto any trim
        wr_reg(OFS_CORE_A_DUAL_MODE + 12'h001, 8'h5A);
        rd_all();
    endtask
    task automatic t_sel();
        logic [7:0] ea [4], eb [4], ec [4];
        ea = '{cur[0], cur[2], cur[2], cur[6]};
        eb = '{cur[1], cur[5], cur[5], 8'h00};
        ec = '{8'h00, cur[3], cur[4], 8'h00};
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            // Dual mode keeps background set to prove its priority
            dual <= (m == 3); bg <= (m != 0); ph <= (m == 2);
            repeat (2) @(posedge clk);
            #1 chk("core_a", ea[m], ca);
            chk("core_b", eb[m], cb);
            chk("core_c", ec[m], cc);
            rd_all();
        end
    endtask
    // Mid-run reset must reload the fuse values over the written ones
    task automatic t_rerst();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("core_a_rst", TRIM_IDLE, ca);
        @(posedge clk);
        rst <= 1'b0;
        cur = fac;
        rd_all();
        #1 chk("core_a_dual", cur[IDX_CORE_A_DUAL_MODE], ca);
    endtask
    task automatic results();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_write();
        t_sel();
        t_rerst();
        results();
    end
endmodule
